// ---- pkg/synth_div_pkg.sv ----
`default_nettype none
package synth_div_pkg;
  // ****************************************
  // Register indices; byte address is index times four
  // ****************************************
  localparam int unsigned BYTE_ADDR_SCALE = 4;
  localparam logic [7:0] CHAN_A_FRAC_MID_BYTE_INDEX = 8'h0B;
  localparam logic [7:0] CHAN_A_FRAC_TOP_BITS_INDEX = 8'h0C;
  localparam logic [7:0] CHAN_B_INTEGER_OFFSET_INDEX = 8'h0D;
  localparam logic [7:0] CHAN_B_FRAC_LOW_BYTE_INDEX = 8'h0E;
  localparam logic [7:0] CHAN_A_FRAC_MID_BYTE_ADDR = 8'(CHAN_A_FRAC_MID_BYTE_INDEX * BYTE_ADDR_SCALE);
  localparam logic [7:0] CHAN_A_FRAC_TOP_BITS_ADDR = 8'(CHAN_A_FRAC_TOP_BITS_INDEX * BYTE_ADDR_SCALE);
  localparam logic [7:0] CHAN_B_INTEGER_OFFSET_ADDR = 8'(CHAN_B_INTEGER_OFFSET_INDEX * BYTE_ADDR_SCALE);
  localparam logic [7:0] CHAN_B_FRAC_LOW_BYTE_ADDR = 8'(CHAN_B_FRAC_LOW_BYTE_INDEX * BYTE_ADDR_SCALE);
  // ****************************************
  // Field widths and reset values
  // ****************************************
  localparam int unsigned BYTE_WIDTH = 8;
  localparam int unsigned TOP_STORE_WIDTH = 6;
  localparam int unsigned TOP_RATIO_WIDTH = 5;
  localparam int unsigned INT_WIDTH = 7;
  localparam int unsigned RATIO_WIDTH = 21;
  localparam logic [7:0] CHAN_A_FRAC_MID_BYTE_RESET = 8'h00;
  localparam logic [5:0] CHAN_A_FRAC_TOP_BITS_RESET = 6'h10;
  localparam logic [6:0] CHAN_B_INTEGER_OFFSET_RESET = 7'h40;
  localparam logic [7:0] CHAN_B_FRAC_LOW_BYTE_RESET = 8'h00;
  localparam logic [1:0] TOP_UNUSED_BITS = 2'h3;
  localparam logic INT_UNUSED_BIT = 1'b1;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
endpackage : synth_div_pkg
`default_nettype wire

// ---- verilog/byte_reg_cell.sv ----
`default_nettype none
module byte_reg_cell #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] q
);
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end
endmodule : byte_reg_cell
`default_nettype wire

// ---- verilog/synth_channel_divider_regs.sv ----
`default_nettype none
module synth_channel_divider_regs
  import synth_div_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] chan_a_frac_low_in,
  input wire logic [7:0] chan_b_frac_mid_in,
  input wire logic [4:0] chan_b_frac_top_in,
  output logic [20:0] chan_a_frac_ratio,
  output logic [20:0] chan_b_frac_ratio,
  output logic [6:0] chan_b_int_offset
);
  // ****************************************
  // Bus decode
  // ****************************************
  logic setup_phase;
  logic write_commit;
  logic hit_a_mid;
  logic hit_a_top;
  logic hit_b_int;
  logic hit_b_low;
  logic addr_hit;
  logic [7:0] a_mid_q;
  logic [5:0] a_top_q;
  logic [6:0] b_int_q;
  logic [7:0] b_low_q;
  logic [31:0] read_value;

  assign setup_phase = psel && !penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign write_commit = psel && penable && pwrite && addr_hit;
  assign hit_a_mid = (paddr == CHAN_A_FRAC_MID_BYTE_ADDR);
  assign hit_a_top = (paddr == CHAN_A_FRAC_TOP_BITS_ADDR);
  assign hit_b_int = (paddr == CHAN_B_INTEGER_OFFSET_ADDR);
  assign hit_b_low = (paddr == CHAN_B_FRAC_LOW_BYTE_ADDR);
  assign addr_hit = hit_a_mid || hit_a_top || hit_b_int || hit_b_low;

  // ****************************************
  // Storage
  // ****************************************
  byte_reg_cell #(.WIDTH(BYTE_WIDTH), .RESET_VALUE(CHAN_A_FRAC_MID_BYTE_RESET)) a_mid_cell (
    .clock(clock),
    .rst(rst),
    .wr_en(write_commit && hit_a_mid),
    .wr_data(pwdata[BYTE_WIDTH-1:0]),
    .q(a_mid_q)
  );

  // Reserved bit 5 is stored as written so a read-modify-write keeps it
  byte_reg_cell #(.WIDTH(TOP_STORE_WIDTH), .RESET_VALUE(CHAN_A_FRAC_TOP_BITS_RESET)) a_top_cell (
    .clock(clock),
    .rst(rst),
    .wr_en(write_commit && hit_a_top),
    .wr_data(pwdata[TOP_STORE_WIDTH-1:0]),
    .q(a_top_q)
  );

  byte_reg_cell #(.WIDTH(INT_WIDTH), .RESET_VALUE(CHAN_B_INTEGER_OFFSET_RESET)) b_int_cell (
    .clock(clock),
    .rst(rst),
    .wr_en(write_commit && hit_b_int),
    .wr_data(pwdata[INT_WIDTH-1:0]),
    .q(b_int_q)
  );

  byte_reg_cell #(.WIDTH(BYTE_WIDTH), .RESET_VALUE(CHAN_B_FRAC_LOW_BYTE_RESET)) b_low_cell (
    .clock(clock),
    .rst(rst),
    .wr_en(write_commit && hit_b_low),
    .wr_data(pwdata[BYTE_WIDTH-1:0]),
    .q(b_low_q)
  );

  // ****************************************
  // Read path
  // ****************************************
  // Unused bits 7:6 of the top-bits register and bit 7 of the offset register are hard-wired high, so they read one; bits 31:8 read zero
  always_comb begin
    read_value = READ_ZERO;
    unique case (1'b1)
      hit_a_mid: read_value = {24'h00_0000, a_mid_q};
      hit_a_top: read_value = {24'h00_0000, TOP_UNUSED_BITS, a_top_q};
      hit_b_int: read_value = {24'h00_0000, INT_UNUSED_BIT, b_int_q};
      hit_b_low: read_value = {24'h00_0000, b_low_q};
      default: read_value = READ_ZERO;
    endcase
  end

  // Data is sampled in the setup cycle so it is stable through the access cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= READ_ZERO;
    end else if (setup_phase) begin
      prdata <= pwrite ? READ_ZERO : read_value;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !addr_hit;
    end
  end

  // ****************************************
  // Divider outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      chan_a_frac_ratio <= {CHAN_A_FRAC_TOP_BITS_RESET[TOP_RATIO_WIDTH-1:0], CHAN_A_FRAC_MID_BYTE_RESET, 8'h00};
    end else begin
      chan_a_frac_ratio <= {a_top_q[TOP_RATIO_WIDTH-1:0], a_mid_q, chan_a_frac_low_in};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      chan_b_frac_ratio <= {13'h0000, CHAN_B_FRAC_LOW_BYTE_RESET};
    end else begin
      chan_b_frac_ratio <= {chan_b_frac_top_in, chan_b_frac_mid_in, b_low_q};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      chan_b_int_offset <= CHAN_B_INTEGER_OFFSET_RESET;
    end else begin
      chan_b_int_offset <= b_int_q;
    end
  end
endmodule : synth_channel_divider_regs
`default_nettype wire

// ---- verification/synth_div_sva.sv ----
`default_nettype none
module synth_div_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [7:0] chan_a_frac_low_in,
  input wire logic [20:0] chan_a_frac_ratio,
  input wire logic [20:0] chan_b_frac_ratio,
  input wire logic [6:0] chan_b_int_offset
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence wr(a); psel && penable && pwrite && paddr == a; endsequence
  sequence rd(a); psel && penable && !pwrite && paddr == a; endsequence
  mid_byte_a: assert property (wr(8'h2C) |-> ##2 chan_a_frac_ratio[15:8] == $past(pwdata[7:0], 2))
    else $error("mid");
  top_bits_a: assert property (wr(8'h30) |-> ##2 chan_a_frac_ratio[20:16] == $past(pwdata[4:0], 2))
    else $error("top");
  int_offset_a: assert property (wr(8'h34) |-> ##2 chan_b_int_offset == $past(pwdata[6:0], 2))
    else $error("int");
  low_byte_a: assert property (wr(8'h38) |-> ##2 chan_b_frac_ratio[7:0] == $past(pwdata[7:0], 2))
    else $error("low");
  reset_vals_a: assert property ($past(rst) |-> chan_a_frac_ratio[20:8] == 13'h1000
    && chan_b_frac_ratio[7:0] == 8'h00 && chan_b_int_offset == 7'h40) else $error("reset");
  ratio_join_a: assert property (!$past(rst) |-> chan_a_frac_ratio[7:0] == $past(chan_a_frac_low_in))
    else $error("join");
  top_unused_a: assert property (rd(8'h30) |-> prdata[7:6] == 2'h3)
    else $error("top unused");
  int_unused_a: assert property (rd(8'h34) |-> prdata[7])
    else $error("int unused");
endmodule : synth_div_sva
`default_nettype wire

// ---- verification/tb_synth_channel_divider_regs.sv ----
`default_nettype none
module tb_synth_channel_divider_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00, chan_a_frac_low_in = 8'h5A, chan_b_frac_mid_in = 8'hC3;
  logic [4:0] chan_b_frac_top_in = 5'h15;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [20:0] chan_a_frac_ratio, chan_b_frac_ratio;
  logic [6:0] chan_b_int_offset;
  logic [7:0] ad [4] = '{8'h2C, 8'h30, 8'h34, 8'h38};
  logic [7:0] rv [4] = '{8'h00, 8'hD0, 8'hC0, 8'h00};
  int error_cnt = 0, checks = 0;
  always #25 clock = ~clock;
  synth_channel_divider_regs dut (
    .clock(clock),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .chan_a_frac_low_in(chan_a_frac_low_in),
    .chan_b_frac_mid_in(chan_b_frac_mid_in),
    .chan_b_frac_top_in(chan_b_frac_top_in),
    .chan_a_frac_ratio(chan_a_frac_ratio),
    .chan_b_frac_ratio(chan_b_frac_ratio),
    .chan_b_int_offset(chan_b_int_offset)
  );
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    repeat (1000) @(posedge clock);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk("reset read", rd, {24'h0, rv[i]});
      chk("mapped error", {31'h0, er}, 32'h0);
    end
    chk("ratio a", {11'h0, chan_a_frac_ratio}, 32'h10005A);
    chk("int offset", {25'h0, chan_b_int_offset}, 32'h40);
    // Reserved top bit is always sent as zero
    for (int i = 0; i < 4; i++) apb(1'b1, ad[i], i == 1 ? 32'hFFFFFFDF : 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk("full read", rd, i == 1 ? 32'hDF : 32'hFF);
    end
    chk("ratio b", {11'h0, chan_b_frac_ratio}, 32'h15C3FF);
    chk("ratio a full", {11'h0, chan_a_frac_ratio}, 32'h1FFF5A);
    chk("int offset full", {25'h0, chan_b_int_offset}, 32'h7F);
    // Off-word and unmapped addresses must neither store nor answer with data
    apb(1'b1, 8'h2D, 32'h0);
    chk("unaligned error", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped read", rd, 32'h0);
    apb(1'b0, 8'h2C, 32'h0);
    chk("mid kept", rd, 32'hFF);
    apb(1'b1, 8'h30, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk("top read", rd, 32'hC0);
    // Second reset in mid-run, with new neighbour bytes on the ratio inputs
    chan_a_frac_low_in <= 8'hA5;
    chan_b_frac_mid_in <= 8'h3C;
    chan_b_frac_top_in <= 5'h0A;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk("second reset read", rd, {24'h0, rv[i]});
    end
    chk("ratio a low in", {11'h0, chan_a_frac_ratio}, 32'h1000A5);
    chk("ratio b reset", {11'h0, chan_b_frac_ratio}, 32'h0A3C00);
    chk("int offset reset", {25'h0, chan_b_int_offset}, 32'h40);
    end_sim();
  end
endmodule : tb_synth_channel_divider_regs
bind synth_channel_divider_regs synth_div_sva chk_i (
  .clock(clock),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .chan_a_frac_low_in(chan_a_frac_low_in),
  .chan_a_frac_ratio(chan_a_frac_ratio),
  .chan_b_frac_ratio(chan_b_frac_ratio),
  .chan_b_int_offset(chan_b_int_offset)
);
`default_nettype wire
